// ===== design/sixio_top.sv
// Six general purpose pin configuration block with AHB-Lite register slave
//
// Behaviour
// - control bit 7: 0 output, 1 input
// - control bits 6:0 hold pin function
// - reset codes 0x27..0x2A outputs, pin5 input 0x10
// - polarity bits: 0 active low, 1 high
// - input edge: polarity 0 falling, 1 rising
// - pad option bit 7 selects extra drive
// - pad option bit 6 makes pins 0,1 analog
// - pad option bits 5:0 enable pull-ups
// - output function selects internal signal routed
// - input function up to 0x0F picks instruction, higher codes none
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "sixio_params.svh"
module sixio_top #(
  parameter int SIGNAL_COUNT = 128
) (
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire logic [SIGNAL_COUNT-1:0] internal_signals,
  input  wire logic [5:0]              pin_in,
  output logic      [5:0]              pin_out,
  output logic      [5:0]              pin_oe_n,
  output logic      [5:0]              pullup_enables,
  output logic                         extra_drive_select,
  output logic                         analog_pad_enable,
  output logic                         instr_strobe,
  output logic      [3:0]              instr_number,
  output logic      [5:0]              instr_pin
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    sixio_pkg::sixio_ctrl_type [5:0] ctrl;
    logic [5:0]  polarity;
    logic [7:0]  pad;
    logic        wr_pend;
    logic [7:0]  wr_idx;
    logic [31:0] rdata;
    logic [5:0]  pin_out;
    logic [5:0]  pin_oe_n;
    logic        strobe;
    logic [3:0]  instr;
    logic [5:0]  instr_pin;
    logic        ready;
    logic        resp;
  } sixio_top_type;

  sixio_top_type state;
  sixio_top_type next_state;

  sixio_edge_if edge_bus ();

  sixio_in_stage u_in_stage (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .pin_in    (pin_in),
    .edge_port (edge_bus)
  );

  assign edge_bus.polarity = state.polarity;

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic       addr_take;
  logic [7:0] addr_idx;

  assign addr_take = hsel && hready && htrans[1];
  // Only the word index is decoded; upper address bits alias the map
  assign addr_idx  = haddr[9:2];

  function automatic logic [31:0] read_word(input sixio_top_type s, input logic [7:0] idx,
                                            input logic [5:0] lvl);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (idx >= `SIXIO_IDX_PIN0_CONTROL && idx <= `SIXIO_IDX_PIN5_CONTROL) begin
      w[7:0] = s.ctrl[3'(idx - `SIXIO_IDX_PIN0_CONTROL)];
    end else if (idx == `SIXIO_IDX_PIN_POLARITY) begin
      w[5:0] = s.polarity; // bits 7:6 stay zero
    end else if (idx == `SIXIO_IDX_PAD_OPTIONS) begin
      w[7:0] = s.pad;
    end else if (idx == `SIXIO_IDX_PIN_INPUTS) begin
      w[5:0] = lvl;
    end
    return w;
  endfunction

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    next_state = state;
    // Register writes land in the data phase
    if (state.wr_pend) begin
      if (state.wr_idx >= `SIXIO_IDX_PIN0_CONTROL && state.wr_idx <= `SIXIO_IDX_PIN5_CONTROL) begin
        next_state.ctrl[3'(state.wr_idx - `SIXIO_IDX_PIN0_CONTROL)] = hwdata[7:0];
      end else if (state.wr_idx == `SIXIO_IDX_PIN_POLARITY) begin
        next_state.polarity = hwdata[5:0];
      end else if (state.wr_idx == `SIXIO_IDX_PAD_OPTIONS) begin
        next_state.pad = hwdata[7:0];
      end
    end
    next_state.wr_pend = addr_take && hwrite;
    next_state.wr_idx  = addr_idx;
    // Read from the post-write copy so a read right behind a write sees the new value
    if (addr_take && !hwrite) begin
      next_state.rdata = read_word(next_state, addr_idx, edge_bus.level);
    end
    // Zero wait states, always OKAY
    next_state.ready = 1'b1;
    next_state.resp  = 1'b0;

    // Output path: mux then polarity inversion
    for (int i = 0; i < 6; i++) begin
      logic sel_sig;
      sel_sig = internal_signals[state.ctrl[i].func];
      next_state.pin_out[i]  = state.polarity[i] ? sel_sig : !sel_sig;
      // Analog mode tri-states pins 0 and 1
      next_state.pin_oe_n[i] = state.ctrl[i].in
                               || (i < 2 && state.pad[`SIXIO_BIT_ANALOG]);
    end

    // Input instruction trigger; lowest pin wins on coincident edges
    next_state.strobe    = 1'b0;
    next_state.instr     = 4'h0;
    next_state.instr_pin = 6'h00;
    for (int i = 5; i >= 0; i--) begin
      if (edge_bus.active_edge[i] && state.ctrl[i].in
          && state.ctrl[i].func <= `SIXIO_INSTR_LIMIT) begin
        next_state.strobe    = 1'b1;
        next_state.instr     = state.ctrl[i].func[3:0];
        next_state.instr_pin = 6'(1 << i);
      end
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state.ctrl[0]   <= `SIXIO_RST_PIN0_CONTROL;
      state.ctrl[1]   <= `SIXIO_RST_PIN1_CONTROL;
      state.ctrl[2]   <= `SIXIO_RST_PIN2_CONTROL;
      state.ctrl[3]   <= `SIXIO_RST_PIN3_CONTROL;
      state.ctrl[4]   <= `SIXIO_RST_PIN4_CONTROL;
      state.ctrl[5]   <= `SIXIO_RST_PIN5_CONTROL;
      state.polarity  <= `SIXIO_RST_POLARITY;
      state.pad       <= `SIXIO_RST_PAD_OPTIONS;
      state.wr_pend   <= 1'b0;
      state.wr_idx    <= 8'h00;
      state.rdata     <= 32'h0000_0000;
      state.pin_out   <= 6'h00;
      state.pin_oe_n  <= 6'h3f;
      state.strobe    <= 1'b0;
      state.instr     <= 4'h0;
      state.instr_pin <= 6'h00;
      state.ready     <= 1'b1;
      state.resp      <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign hrdata             = state.rdata;
  assign hreadyout          = state.ready;
  assign hresp              = state.resp;
  assign pin_out            = state.pin_out;
  assign pin_oe_n           = state.pin_oe_n;
  assign pullup_enables     = state.pad[5:0];
  assign extra_drive_select = state.pad[`SIXIO_BIT_EXTRA_DRIVE];
  assign analog_pad_enable  = state.pad[`SIXIO_BIT_ANALOG];
  assign instr_strobe       = state.strobe;
  assign instr_number       = state.instr;
  assign instr_pin          = state.instr_pin;

endmodule

// ===== design/sixio_params.svh
// Register offsets, field positions and reset values of the six-pin IO block
`ifndef SIXIO_PARAMS_SVH
`define SIXIO_PARAMS_SVH

// Printed offsets are not all multiples of four: they are indices, byte address = 4 * index
`define SIXIO_IDX_PIN0_CONTROL  8'h20
`define SIXIO_IDX_PIN1_CONTROL  8'h21
`define SIXIO_IDX_PIN2_CONTROL  8'h22
`define SIXIO_IDX_PIN3_CONTROL  8'h23
`define SIXIO_IDX_PIN4_CONTROL  8'h24
`define SIXIO_IDX_PIN5_CONTROL  8'h25
`define SIXIO_IDX_PIN_POLARITY  8'h26
`define SIXIO_IDX_PAD_OPTIONS   8'h28
`define SIXIO_IDX_PIN_INPUTS    8'h29

`define SIXIO_RST_PIN0_CONTROL  8'h00
`define SIXIO_RST_PIN1_CONTROL  8'h27
`define SIXIO_RST_PIN2_CONTROL  8'h28
`define SIXIO_RST_PIN3_CONTROL  8'h29
`define SIXIO_RST_PIN4_CONTROL  8'h2a
`define SIXIO_RST_PIN5_CONTROL  8'h90
`define SIXIO_RST_POLARITY      6'h3f
`define SIXIO_RST_PAD_OPTIONS   8'h00

`define SIXIO_BIT_DIRECTION     7
`define SIXIO_BIT_EXTRA_DRIVE   7
`define SIXIO_BIT_ANALOG        6
`define SIXIO_INSTR_LIMIT       7'h0f

`endif

// ===== design/sixio_pkg.sv
// Types shared by the six-pin IO block
package sixio_pkg;

  typedef logic [7:0] sixio_byte_type;

  typedef struct packed {
    logic       in;
    logic [6:0] func;
  } sixio_ctrl_type;

endpackage

// ===== design/sixio_edge_if.sv
// Carrier between the pin synchroniser/edge stage and the register top
`timescale 1ns/1ps
interface sixio_edge_if;
  logic [5:0] level;
  logic [5:0] active_edge;
  logic [5:0] polarity;
  modport stage (input polarity, output level, output active_edge);
  modport top   (output polarity, input level, input active_edge);
endinterface

// ===== design/sixio_in_stage.sv
// Three-flop pin synchroniser with polarity-aware active-edge detection
`timescale 1ns/1ps
module sixio_in_stage (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  input  wire logic [5:0] pin_in,
  sixio_edge_if.stage edge_port
);

  typedef struct packed {
    logic [5:0] meta;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] level;
    logic [5:0] pulse;
    logic [5:0] seen;
  } sixio_stage_type;

  sixio_stage_type state;
  sixio_stage_type next_state;

  always_comb begin
    next_state       = state;
    next_state.meta  = pin_in;
    next_state.s2    = state.meta;
    next_state.s3    = state.s2;
    next_state.pulse = '0;
    for (int i = 0; i < 6; i++) begin
      // A change counts once the second and third stages agree
      if (state.s2[i] == state.s3[i]
          && (!state.seen[i] || state.s3[i] != state.level[i])) begin
        next_state.seen[i]  = 1'b1;
        next_state.level[i] = state.s3[i];
        // First settled level after reset is the reset 0 in s2/s3, taken without an edge; a pin high at reset then gives a rising edge
        // Rising edge active when polarity is 1, falling when 0
        next_state.pulse[i] = state.seen[i] && (state.s3[i] == edge_port.polarity[i]);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign edge_port.level       = state.level;
  assign edge_port.active_edge = state.pulse;

endmodule

// ===== testbench/sixio_props.sv
// Concurrent checks on the ports of the six-pin IO block
`timescale 1ns/1ps
`include "sixio_params.svh"
module sixio_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [5:0]  pin_oe_n,
  input wire logic [5:0]  pullup_enables,
  input wire logic        extra_drive_select,
  input wire logic        analog_pad_enable,
  input wire logic        instr_strobe,
  input wire logic [5:0]  instr_pin
);
  // ==========
  // Data phase tracking
  logic       wr_pend;
  logic       rd_pend;
  logic [7:0] idx;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      idx     <= 8'h00;
    end else begin
      wr_pend <= hsel & hready & htrans[1] & hwrite;
      rd_pend <= hsel & hready & htrans[1] & !hwrite;
      idx     <= haddr[9:2];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========
  // Properties
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
  a_ready_high: assert property (hreadyout == 1'b1) else $error("wait state");
  a_pad_write: assert property (wr_pend && idx == `SIXIO_IDX_PAD_OPTIONS |=>
    {extra_drive_select, analog_pad_enable, pullup_enables} == $past(hwdata[7:0]))
    else $error("pad options not applied");
  a_dir_write: assert property (wr_pend && idx == `SIXIO_IDX_PIN3_CONTROL |->
    ##2 pin_oe_n[3] == $past(hwdata[7], 2)) else $error("direction not applied");
  a_pol_reserved: assert property (rd_pend && idx == `SIXIO_IDX_PIN_POLARITY |->
    hrdata[31:6] == 26'h000_0000) else $error("reserved polarity bits set");
  a_analog_float: assert property ($past(analog_pad_enable) && analog_pad_enable |->
    pin_oe_n[1:0] == 2'b11) else $error("analog pin driven");
  a_strobe_onehot: assert property (instr_strobe |-> $onehot(instr_pin))
    else $error("strobe pin not one-hot");
  a_strobe_input: assert property (instr_strobe |-> (instr_pin & ~pin_oe_n) == 6'h00)
    else $error("strobe from output pin");
  c_pad: cover property (wr_pend && idx == `SIXIO_IDX_PAD_OPTIONS);
  c_strobe: cover property (instr_strobe);
  c_analog: cover property (analog_pad_enable);
endmodule

// ===== testbench/sixio_pad_model.sv
// Board side of the six pads: external drivers, pull-ups and floating lines
`timescale 1ns/1ps
module sixio_pad_model (
  input  wire logic       hclk,
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe_n,
  input  wire logic [5:0] pullup_enables,
  input  wire logic [5:0] ext_drive,
  input  wire logic [5:0] ext_level,
  output logic      [5:0] pin_in
);
  logic [5:0] last = 6'h00;
  always @(posedge hclk) last <= pin_in;
  // A floating pad shows a changing level, never a convenient one
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (ext_drive[i]) pin_in[i] = ext_level[i];
      else if (pullup_enables[i]) pin_in[i] = 1'b1;
      else pin_in[i] = ~last[i];
    end
  end
endmodule

// ===== testbench/tb_top.sv
// Register-level tests of the six-pin IO block
`timescale 1ns/1ps
`include "sixio_params.svh"
module tb_top;
  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  logic         hsel = 1'b0;
  logic [31:0]  haddr = 32'h0000_0000;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0;
  logic [2:0]   hsize = 3'h2;
  logic [31:0]  hwdata = 32'h0000_0000;
  logic [31:0]  hrdata, rd;
  logic         hreadyout, hresp, extra_drive_select, analog_pad_enable, instr_strobe;
  logic [127:0] internal_signals = {4{32'h5a5a_c3c3}};
  logic [5:0]   pin_in, pin_out, pin_oe_n, pullup_enables, instr_pin, seen_pin;
  logic [5:0]   ext_drive = 6'h00;
  logic [5:0]   ext_level = 6'h00;
  logic [3:0]   instr_number, seen_num;
  logic         seen_lvl;
  int           errors = 0;
  int           samples_checked = 0;
  int           strobes = 0;
  int           strobe_base = 0;
  logic [7:0]   idx_tab [9] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h28, 8'h27};
  logic [7:0]   rst_tab [9] = '{8'h00, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h90, 8'h3f, 8'h00, 8'h00};
  logic [6:0]   fn_tab [3] = '{7'h03, 7'h0f, 7'h13};
  always #4 hclk = ~hclk;
  sixio_top sixio_top_inst (.*, .hready(hreadyout));
  sixio_pad_model sixio_pad_model_inst (.*);
  always @(posedge hclk) if (instr_strobe) begin
    strobes++;
    seen_num = instr_number;
    seen_pin = instr_pin;
    seen_lvl = ext_level[3];
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h00_0000, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #40000;
    errors++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (idx_tab[i]) begin
      bus(1'b0, idx_tab[i], 32'h0000_0000);
      check(rd, 32'(rst_tab[i]));
    end
    check(32'(pin_oe_n), 32'h0000_0020);
    check(32'(pin_out[4:1]), 32'(internal_signals[42:39]));
    bus(1'b1, `SIXIO_IDX_PIN_POLARITY, 32'h0000_00ff);
    bus(1'b0, `SIXIO_IDX_PIN_POLARITY, 32'h0000_0000);
    check(rd, 32'h0000_003f);
    $display("test register_reset done");
    bus(1'b1, `SIXIO_IDX_PIN1_CONTROL, 32'h0000_00a7);
    bus(1'b1, `SIXIO_IDX_PAD_OPTIONS, 32'h0000_00c5);
    repeat (3) @(posedge hclk);
    check(32'({extra_drive_select, analog_pad_enable, pullup_enables}), 32'h0000_00c5);
    check(32'(pin_oe_n[1:0]), 32'h0000_0003);
    bus(1'b1, `SIXIO_IDX_PAD_OPTIONS, 32'h0000_0000);
    repeat (3) @(posedge hclk);
    check(32'(pin_oe_n[1:0]), 32'h0000_0002);
    $display("test pad_options done");
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, `SIXIO_IDX_PIN2_CONTROL, 32'(5 + k % 2));
      bus(1'b1, `SIXIO_IDX_PIN_POLARITY, (k > 1) ? 32'h0000_003f : 32'h0000_003b);
      repeat (3) @(posedge hclk);
      check(32'(pin_out[2]), 32'(internal_signals[5 + k % 2] ^ (k < 2)));
      check(32'(pin_oe_n[2]), 32'h0000_0000);
    end
    $display("test output_mux done");
    ext_drive <= 6'h08;
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, `SIXIO_IDX_PIN3_CONTROL, 32'h0000_0080 | 32'(fn_tab[k / 2]));
      bus(1'b1, `SIXIO_IDX_PIN_POLARITY, (k % 2) ? 32'h0000_003f : 32'h0000_0037);
      repeat (10) @(posedge hclk);
      strobe_base = strobes;
      repeat (2) begin
        ext_level[3] <= ~ext_level[3];
        repeat (10) @(posedge hclk);
      end
      check(32'(strobes - strobe_base), 32'(fn_tab[k / 2] < 16));
      if (fn_tab[k / 2] < 16) begin
        check(32'({seen_pin, seen_num}), 32'({6'h08, fn_tab[k / 2][3:0]}));
        check(32'(seen_lvl), 32'(k % 2));
      end
    end
    $display("test input_edges done");
    ext_level[3] <= 1'b1;
    repeat (10) @(posedge hclk);
    bus(1'b0, `SIXIO_IDX_PIN_INPUTS, 32'h0000_0000);
    check(32'(rd[3]), 32'h0000_0001);
    $display("test pin_inputs done");
    give_verdict();
  end
endmodule
bind sixio_top sixio_props sixio_props_inst (.*);
